// *** bench/pdm_irq_src.sv ***
// Interrupt source model standing on the CPU side
`timescale 1ns/1ns
`default_nettype none
module pdm_irq_src (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Raise request from the bench
    input wire logic fire,
    input wire logic [4:0] fire_line,
    // Wake indications from the block
    input wire logic wake_isr,
    input wire logic wake_resume,
    // Interrupt lines, level
    output logic [31:0] int_pending
);
    // Lines latch until a wake consumes them; a stale line would re-wake the next sleep
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_pending <= 32'h0000_0000;
        end else if (wake_isr || wake_resume) begin
            // A line raised in the wake cycle survives the clear
            int_pending <= fire ? (32'h0000_0001 << fire_line) : 32'h0000_0000;
        end else if (fire) begin
            int_pending <= int_pending | (32'h0000_0001 << fire_line);
        end
    end
endmodule
`default_nettype wire

// *** bench/pdm_top_sva.sv ***
// Port checker for the power-down mode controller
`timescale 1ns/1ns
`default_nettype none
module pdm_top_sva #(
    parameter int LOCK_CYCLES = pdm_pkg::PLL_LOCK_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Observed outputs
    input wire logic s_axi_bvalid,
    input wire logic cpu_clk_en,
    input wire logic int_clk_en,
    input wire logic dma_clk_en,
    input wire logic pll_out_en,
    input wire logic pll_in_en,
    input wire logic io_freeze,
    input wire logic pll_locked,
    input wire logic wake_isr,
    input wire logic wake_resume
);
    // Edges since reset release, saturating so it never wraps
    int unsigned rel_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rel_cnt <= 0;
        end else if (rel_cnt < 100000) begin
            rel_cnt <= rel_cnt + 1;
        end
    end
    // One clock domain, so one default for all
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_entry_delay: assert property ($fell(cpu_clk_en) && pll_locked
        |-> $past(s_axi_bvalid, 9) || $past(s_axi_bvalid, 10)) else $error("sleep entry late");
    a_halt_freeze: assert property (!pll_out_en |-> io_freeze && !cpu_clk_en)
        else $error("halt without freeze");
    a_deep_freeze: assert property (!pll_in_en |-> io_freeze && !cpu_clk_en)
        else $error("deep without freeze");
    a_halt_hold: assert property (!pll_out_en |=> !pll_out_en && !wake_isr && !wake_resume)
        else $error("halt left without reset");
    a_deep_hold: assert property ($fell(pll_in_en) |=> !pll_in_en [*8])
        else $error("deep left without reset");
    a_pulse_excl: assert property (not (wake_isr && wake_resume))
        else $error("both wake pulses");
    a_wake_resumes: assert property (wake_isr || wake_resume |-> ##[1:3] cpu_clk_en)
        else $error("no resume after wake");
    a_wake_clocked: assert property (wake_isr || wake_resume
        |-> $past(int_clk_en) && $past(dma_clk_en)) else $error("sleep stopped int or dma");
    a_lock_wait: assert property ($rose(pll_locked) |-> rel_cnt >= LOCK_CYCLES - 1
        && rel_cnt <= LOCK_CYCLES + 1 ##1 cpu_clk_en) else $error("relock wait wrong");
    // Main scenarios reached
    c_isr: cover property (wake_isr);
    c_resume: cover property (wake_resume);
    c_halt: cover property ($fell(pll_out_en));
    c_deep: cover property ($fell(pll_in_en));
endmodule
bind pdm_top pdm_top_sva #(.LOCK_CYCLES(LOCK_CYCLES)) pdm_top_sva_inst (.aclk(aclk),
    .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .cpu_clk_en(cpu_clk_en),
    .int_clk_en(int_clk_en), .dma_clk_en(dma_clk_en), .pll_out_en(pll_out_en),
    .pll_in_en(pll_in_en), .io_freeze(io_freeze), .pll_locked(pll_locked),
    .wake_isr(wake_isr), .wake_resume(wake_resume));
`default_nettype wire

// *** bench/power_down_mode_logic_bench.sv ***
// Self-checking bench for the power-down mode controller
`timescale 1ns/1ns
`default_nettype none
module power_down_mode_logic_bench;
    import pdm_pkg::*;
    localparam int LK = 8; // Short relock wait for simulation
    // Drives
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic fire = 1'b0;
    logic [4:0] fire_line = 5'h00;
    // Block outputs
    logic awready, wready, bvalid, arready, rvalid, cpu_en, int_en, dma_en;
    logic pll_out, pll_in, freeze, locked, w_isr, w_res;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, pend, rd;
    // Counters and light sleep table: encoding, enable bits, pulses
    int n_mismatch = 0, n_tests = 0, n_isr = 0, n_res = 0, b_isr, b_res, k, i;
    logic [5:0] l_enc [3] = '{6'h09, 6'h09, 6'h11};
    logic [31:0] l_low [3] = '{32'h3, 32'h1, 32'h3};
    logic [31:0] l_isr [3] = '{32'h1, 32'h0, 32'h0};
    logic [5:0] d_enc [2] = '{6'h1A, 6'h1C};
    pdm_top #(.LOCK_CYCLES(LK)) pdm_top_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .int_pending(pend), .cpu_clk_en(cpu_en), .int_clk_en(int_en), .dma_clk_en(dma_en),
        .pll_out_en(pll_out), .pll_in_en(pll_in), .io_freeze(freeze), .pll_locked(locked),
        .wake_isr(w_isr), .wake_resume(w_res));
    pdm_irq_src pdm_irq_src_inst (.aclk(aclk), .aresetn(aresetn), .fire(fire),
        .fire_line(fire_line), .wake_isr(w_isr), .wake_resume(w_res), .int_pending(pend));
    // Clock at 50 MHz
    always #10 aclk = ~aclk;
    // Count wake pulses as they pass
    always @(posedge aclk) begin
        n_isr += int'(w_isr === 1'b1);
        n_res += int'(w_res === 1'b1);
    end
    // Compare and tally
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Bus write: address and data together, each released when taken
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask
    // Bus read
    task rdr(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask
    // Raise one interrupt line for a cycle
    task fire_int(input logic [4:0] l);
        @(posedge aclk);
        fire <= 1'b1;
        fire_line <= l;
        @(posedge aclk);
        fire <= 1'b0;
    endtask
    // Bounded wait for the CPU clock enable to reach a level
    task wait_en(input logic v);
        for (k = 0; k < 20 && cpu_en !== v; k++) @(posedge aclk);
        @(posedge aclk);
    endtask
    // Reset, then count edges until the CPU clock runs again
    task do_reset(input int n);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (n) @(posedge aclk);
        aresetn <= 1'b1;
        for (k = 0; k < 40 && cpu_en !== 1'b1; k++) @(posedge aclk);
        chk(32'(k >= LK && k <= LK + 3), 32'h1);
    endtask
    // Verdict
    task final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        n_mismatch++;
        final_report;
    end
    // Test sequence
    initial begin
        do_reset(20);
        rdr(4'h4);
        chk(rd, 32'h0000_0021);
        rdr(4'hC);
        chk({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
        wr(4'hC, 32'h0000_0001);
        chk(32'(rsp), 32'(RESP_SLVERR));
        wr(4'h0, 32'h0000_8003);
        rdr(4'h0);
        chk(rd, 32'h0000_0003);
        wr(4'h0, 32'h0000_1403);
        repeat (14) @(posedge aclk);
        chk(32'(cpu_en), 32'h1);
        $display("test registers done");
        // Light sleep: enabled line 3, non-enabled line 5
        wr(4'h8, 32'h0000_0008);
        for (i = 0; i < 3; i++) begin
            b_isr = n_isr;
            b_res = n_res;
            wr(4'h0, {16'h0, l_enc[i], 10'h0} | l_low[i]);
            wait_en(1'b0);
            chk({29'h0, cpu_en, int_en, dma_en}, 32'h3);
            rdr(4'h4);
            chk(rd, 32'h0000_0024);
            fire_int(5'd5);
            repeat (6) @(posedge aclk);
            if (l_enc[i] == 6'h09) begin
                chk(32'(cpu_en), 32'h0);
                fire_int(5'd3);
            end
            wait_en(1'b1);
            chk(32'(n_isr - b_isr), l_isr[i]);
            chk(32'(n_res - b_res), 32'h1 - l_isr[i]);
            wr(4'h0, 32'h0000_0000);
        end
        $display("test light sleep done");
        // Clock halt and deep sleep, an interrupt must not end them
        for (i = 0; i < 2; i++) begin
            wr(4'h0, {16'h0, d_enc[i], 10'h0});
            wait_en(1'b0);
            chk({30'h0, (i == 1 ? pll_in : pll_out), freeze}, 32'h1);
            fire_int(5'd3);
            repeat (12) @(posedge aclk);
            chk(32'(cpu_en), 32'h0);
            do_reset(3);
        end
        $display("test deep modes done");
        final_report;
    end
endmodule
`default_nettype wire

// *** hdl/pdm_pkg.sv ***
// Shared constants and types for the power-down mode logic
`default_nettype none
package pdm_pkg;
    // Register map (byte addresses)
    localparam logic [3:0] CTRL_STATUS_OFFSET = 4'h0;
    localparam logic [3:0] SLEEP_STATUS_OFFSET = 4'h4;
    localparam logic [3:0] INT_ENABLE_OFFSET = 4'h8;
    // Field positions in the control/status word
    localparam int PD_FIELD_LSB = 10;
    localparam int PD_FIELD_MSB = 15;
    localparam int GIE_BIT = 0;
    localparam int NMI_ENABLE_BIT = 1;
    // Reset values
    localparam logic [31:0] CTRL_STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] INT_ENABLE_RESET = 32'h0000_0000;
    // Power-down encodings
    localparam logic [5:0] PD_NONE = 6'h00;
    localparam logic [5:0] PD_LIGHT_ENABLED = 6'h09;
    localparam logic [5:0] PD_LIGHT_ANY = 6'h11;
    localparam logic [5:0] PD_CLOCK_HALT = 6'h1A;
    localparam logic [5:0] PD_DEEP = 6'h1C;
    // Entry delay into light sleep, in clock cycles
    localparam int LIGHT_ENTRY_CYCLES = 8;
    // Clock rate and PLL relock time after deep sleep
    localparam int CLK_MHZ = 50;
    localparam int PLL_LOCK_US = 75;
    localparam int PLL_LOCK_CYCLES = PLL_LOCK_US * CLK_MHZ;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Sleep state, one-hot
    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_ENTER = 5'h02,
        ST_LIGHT = 5'h04,
        ST_HALT = 5'h08,
        ST_DEEP = 5'h10
    } pdm_state_t;
endpackage
`default_nettype wire

// *** hdl/pdm_top.sv ***
// Power-down mode controller with AXI4-Lite register slave
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Six-bit field selects mode and wake
// - Light sleep begins eight cycles after write
// - Non-enabled wake resumes without service
// - Enabled wake runs service then resumes
// - Service needs global and nmi enables
// - Halt and deep end only by reset
// - 001001 light sleep, enabled wake only
// - 010001 light sleep, any interrupt wakes
// - 011010 stops PLL output clock
// - 011100 stops PLL input clock
// - Light sleep keeps interrupt logic clocked
// - Light sleep gates CPU boundary clocks
// - Light sleep keeps DMA running
// - Deep modes retain registers and RAM
// - Deep modes freeze functional outputs
// - After deep sleep wait PLL relock
// - Async peripherals may still toggle
module pdm_top #(
    parameter int LOCK_CYCLES = pdm_pkg::PLL_LOCK_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt lines from the peripherals (same clock)
    input wire logic [31:0] int_pending,
    // Clock and activity controls
    output logic cpu_clk_en,
    output logic int_clk_en,
    output logic dma_clk_en,
    output logic pll_out_en,
    output logic pll_in_en,
    output logic io_freeze,
    output logic pll_locked,
    // Wake indications to the CPU, one-cycle pulses
    output logic wake_isr,
    output logic wake_resume
);
    import pdm_pkg::*;

    // Registers
    logic [31:0] csr_reg;
    logic [31:0] ier_reg;
    pdm_state_t state_reg;
    logic [3:0] enter_cnt_reg;
    logic [5:0] pending_mode_reg;
    logic [$clog2(LOCK_CYCLES+1)-1:0] lock_cnt_reg;
    // Bus latches
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [3:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    // Wake decoder connection
    pdm_wake_if wif ();
    assign wif.int_pending = int_pending;
    assign wif.int_enable = ier_reg;
    assign wif.global_int_enable = csr_reg[GIE_BIT];
    assign wif.nmi_enable = csr_reg[NMI_ENABLE_BIT];
    pdm_wake_dec u_dec (
        .w(wif)
    );

    // Byte-lane merge, shared by both writable registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Field decode into a supported mode; others map to none
    function automatic logic [5:0] legal_mode(input logic [5:0] f);
        case (f)
            PD_LIGHT_ENABLED, PD_LIGHT_ANY, PD_CLOCK_HALT, PD_DEEP: legal_mode = f;
            default: legal_mode = PD_NONE;
        endcase
    endfunction

    // Write is committed when both halves are held and response channel is free
    logic wr_go;
    assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    logic csr_write;
    assign csr_write = wr_go && (aw_addr_reg[3:2] == CTRL_STATUS_OFFSET[3:2]);
    logic [31:0] csr_written;
    assign csr_written = merge(csr_reg, w_data_reg, w_strb_reg);

    // Write address capture; taken independently of data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_hold_reg <= 1'b0;
        end
    end

    // Write data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_go) begin
            w_hold_reg <= 1'b0;
        end
    end

    // Ready flags: one cycle of ready per accepted beat
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
        end
    end

    // Write response; unmapped offsets answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr_reg[3:2] == CTRL_STATUS_OFFSET[3:2] ||
                aw_addr_reg[3:2] == INT_ENABLE_OFFSET[3:2]) begin
                s_axi_bresp <= RESP_OKAY;
            end else begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control/status register; whole field taken in one write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            csr_reg <= CTRL_STATUS_RESET;
        end else if (csr_write) begin
            csr_reg <= csr_written;
            csr_reg[PD_FIELD_MSB] <= 1'b0; // Reserved bit kept zero
        end
    end

    // Interrupt enable register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ier_reg <= INT_ENABLE_RESET;
        end else if (wr_go && aw_addr_reg[3:2] == INT_ENABLE_OFFSET[3:2]) begin
            ier_reg <= merge(ier_reg, w_data_reg, w_strb_reg);
        end
    end

    // Read channel; state readable so software sees the mode in force
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_rvalid) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr[3:2])
                CTRL_STATUS_OFFSET[3:2]: s_axi_rdata <= csr_reg;
                SLEEP_STATUS_OFFSET[3:2]: s_axi_rdata <= {26'h0, pll_locked, state_reg};
                INT_ENABLE_OFFSET[3:2]: s_axi_rdata <= ier_reg;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
    end

    // Entry countdown; counts every cycle from the write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enter_cnt_reg <= 4'h0;
            pending_mode_reg <= PD_NONE;
        end else if (csr_write && state_reg == ST_RUN &&
            legal_mode(csr_written[PD_FIELD_MSB:PD_FIELD_LSB]) != PD_NONE) begin
            enter_cnt_reg <= 4'(LIGHT_ENTRY_CYCLES - 1);
            pending_mode_reg <= legal_mode(csr_written[PD_FIELD_MSB:PD_FIELD_LSB]);
        end else if (enter_cnt_reg != 4'h0) begin
            enter_cnt_reg <= enter_cnt_reg - 4'h1;
        end
    end

    // Sleep state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_RUN; // Reset is the only exit from deep modes
            wake_isr <= 1'b0;
            wake_resume <= 1'b0;
        end else begin
            wake_isr <= 1'b0;
            wake_resume <= 1'b0;
            case (state_reg)
                ST_RUN: begin
                    if (enter_cnt_reg == 4'h1) begin
                        state_reg <= ST_ENTER;
                    end
                end
                ST_ENTER: begin
                    case (pending_mode_reg)
                        PD_CLOCK_HALT: state_reg <= ST_HALT;
                        PD_DEEP: state_reg <= ST_DEEP;
                        default: state_reg <= ST_LIGHT;
                    endcase
                end
                ST_LIGHT: begin
                    if (wif.wake_enabled) begin
                        state_reg <= ST_RUN;
                        wake_isr <= wif.run_isr;
                        wake_resume <= !wif.run_isr;
                    end else if (wif.wake_any && pending_mode_reg == PD_LIGHT_ANY) begin
                        state_reg <= ST_RUN;
                        wake_resume <= 1'b1; // Resume, no service
                    end
                end
                ST_HALT, ST_DEEP: state_reg <= state_reg; // No interrupt exits
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    // PLL relock wait after reset; deep exit always passes reset, so every reset waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_cnt_reg <= '0;
            pll_locked <= 1'b0;
        end else if (!pll_locked) begin
            if (lock_cnt_reg == ($clog2(LOCK_CYCLES+1))'(LOCK_CYCLES - 1)) begin
                pll_locked <= 1'b1;
            end else begin
                lock_cnt_reg <= lock_cnt_reg + 1'b1;
            end
        end
    end

    // Clock enables; registers and RAM hold because clocks only stop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_clk_en <= 1'b0;
            int_clk_en <= 1'b0;
            dma_clk_en <= 1'b0;
            pll_out_en <= 1'b1;
            pll_in_en <= 1'b1;
            io_freeze <= 1'b0;
        end else begin
            cpu_clk_en <= pll_locked && (state_reg == ST_RUN || state_reg == ST_ENTER);
            int_clk_en <= pll_locked && state_reg != ST_HALT && state_reg != ST_DEEP;
            dma_clk_en <= pll_locked && state_reg != ST_HALT && state_reg != ST_DEEP;
            pll_out_en <= state_reg != ST_HALT;
            pll_in_en <= state_reg != ST_DEEP;
            // Async peripherals are not covered by this freeze
            io_freeze <= state_reg == ST_HALT || state_reg == ST_DEEP;
        end
    end
endmodule
`default_nettype wire

// *** hdl/pdm_wake_dec.sv ***
// Wake decoder: classifies pending interrupts
`timescale 1ns/1ns
`default_nettype none
module pdm_wake_dec (
    pdm_wake_if.dec w
);
    // Any enabled interrupt pending
    assign w.wake_enabled = |(w.int_pending & w.int_enable);
    // Any interrupt at all pending
    assign w.wake_any = |w.int_pending;
    // Service routine only with both global enables set
    assign w.run_isr = w.wake_enabled & w.global_int_enable & w.nmi_enable;
endmodule
`default_nettype wire

// *** hdl/pdm_wake_if.sv ***
// Wake request interface between the top and the wake decoder
`timescale 1ns/1ns
`default_nettype none
interface pdm_wake_if;
    logic [31:0] int_pending;
    logic [31:0] int_enable;
    logic global_int_enable;
    logic nmi_enable;
    logic wake_enabled;
    logic wake_any;
    logic run_isr;
    modport top (output int_pending, output int_enable, output global_int_enable, output nmi_enable,
        input wake_enabled, input wake_any, input run_isr);
    modport dec (input int_pending, input int_enable, input global_int_enable, input nmi_enable,
        output wake_enabled, output wake_any, output run_isr);
endinterface
`default_nettype wire
